// File: rtl/ast_transmitter.sv
/*
 * Asynchronous serial transmitter: one-deep transmit buffer, shifter,
 * baud divider and AXI4-Lite register slave.
 * Assumes one core clock; the remote receiver samples o_serial_out.
 */
// Notes on behaviour
// - Idle line sits at mark level
// - Frame: start, 8/9 data, stop, NRZ
// - Each bit lasts one baud period
// - Data bits go out LSB first
// - Shares format and rate; no parity
// - Active only when enabled, async, port on
// - Port enable drives the serial pin
// - Enabling transmit sets buffer free flag
// - Buffer write loads empty shifter next cycle
// - Queued character waits for previous stop
// - Frame starts right after shifter load
// - Invert flips idle and data polarity
// - Invert acts in async mode only
// - Free flag clear while queued or disabled
// - Free flag settles two cycles, read only
// - Irq enable does not gate flag
// - Shifter empty clears on load, no irq
// - Nine bit mode sends ninth bit last
// - Ninth bit written before buffer data
`timescale 1ns/1ps

module ast_transmitter (
    input  wire logic        i_core_clk,     // Core clock
    input  wire logic        i_rst,          // Async reset, active high
    input  wire logic [4:0]  i_awaddr,       // AXI write address
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,        // AXI write data
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,        // AXI write response
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [4:0]  i_araddr,       // AXI read address
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,        // AXI read data
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic             o_serial_out,   // Serial data to pin
    output logic             o_serial_oe,    // Pin drive enable
    output logic             o_buffer_free   // Buffer free flag level
);
    import ast_pkg::*;

    // Registers
    logic [7:0]  txsta_q;        // transmit_status_control
    logic [7:0]  rcsta_q;        // receive_status_control
    logic [7:0]  baudc_q;        // baud_control
    logic [7:0]  brgl_q;         // baud_divisor_low
    logic [7:0]  high_speed_baud_q;         // baud_divisor_high
    logic [7:0]  txbuf_q;        // transmit_buffer
    logic        txbuf9_q;       // Ninth bit captured with buffer
    logic        full_q;         // Buffer holds a character
    logic        irqen_q;        // transmit_irq_enable
    logic [1:0]  lag_q;          // Settling counter for flag
    logic        free_q;         // transmit_buffer_free_flag
    logic [8:0]  shift_q;        // transmit_shifter
    logic [3:0]  bits_q;         // Bits left incl. start
    logic        line_q;         // Uninverted line level
    logic [15:0] baud_q;         // Baud divider count
    logic        empty_q;        // shifter_empty
    ast_state_t  state_q;        // Shifter state

    // AXI write channel holding
    logic        aw_have_q;
    logic        w_have_q;
    logic [4:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // Decoded controls
    wire active   = txsta_q[AST_TX_EN] & ~txsta_q[AST_TX_SYNC]
                    & rcsta_q[AST_RC_PEN];
    wire nine     = txsta_q[AST_TX_NINE];
    wire [15:0] div_val = baudc_q[AST_BC_WIDE] ? {high_speed_baud_q, brgl_q}
                                               : {8'h00, brgl_q};
    wire baud_tick = (baud_q == 16'h0000);               // End of one bit period
    wire load      = active & full_q & (state_q == AST_IDLE);

    // Write path decode
    wire wr_go     = aw_have_q & w_have_q & ~o_bvalid;
    wire wr_ok     = (aw_addr_q <= AST_OFF_FLAGS) & (aw_addr_q[1:0] == 2'b00);
    wire wr_txsta  = wr_go & (aw_addr_q == AST_OFF_TXSTA)  & w_strb_q[0];
    wire wr_rcsta  = wr_go & (aw_addr_q == AST_OFF_RCSTA)  & w_strb_q[0];
    wire wr_baudc  = wr_go & (aw_addr_q == AST_OFF_BAUDC)  & w_strb_q[0];
    wire wr_brgl   = wr_go & (aw_addr_q == AST_OFF_BRGL)   & w_strb_q[0];
    wire wr_high_speed_baud   = wr_go & (aw_addr_q == AST_OFF_HIGH_SPEED_BAUD)   & w_strb_q[0];
    wire wr_txdata = wr_go & (aw_addr_q == AST_OFF_TXDATA) & w_strb_q[0];
    wire wr_flags  = wr_go & (aw_addr_q == AST_OFF_FLAGS)  & w_strb_q[0];
    wire [7:0] wb  = w_data_q[7:0];

    // AXI handshake outputs
    assign o_awready = ~aw_have_q;
    assign o_wready  = ~w_have_q;
    assign o_arready = ~o_rvalid;

    // Read mux
    wire [7:0] rd_byte =
        (i_araddr == AST_OFF_TXSTA)  ? txsta_q :
        (i_araddr == AST_OFF_RCSTA)  ? rcsta_q :
        (i_araddr == AST_OFF_BAUDC)  ? baudc_q :
        (i_araddr == AST_OFF_BRGL)   ? brgl_q  :
        (i_araddr == AST_OFF_HIGH_SPEED_BAUD)   ? high_speed_baud_q  :
        (i_araddr == AST_OFF_TXDATA) ? txbuf_q :
        (i_araddr == AST_OFF_FLAGS)  ? {6'h00, irqen_q, free_q} : 8'h00;
    wire rd_ok = (i_araddr <= AST_OFF_FLAGS) & (i_araddr[1:0] == 2'b00);

    // Capture write address and data in either order
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (i_awvalid & o_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end
            else if (wr_go)
                aw_have_q <= 1'b0;
            if (i_wvalid & o_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            else if (wr_go)
                w_have_q <= 1'b0;
        end
    end

    // Write response and read data channels
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= AST_RESP_OK;
            o_rvalid <= 1'b0;
            o_rresp  <= AST_RESP_OK;
            o_rdata  <= 32'h0000_0000;
        end
        else
        begin
            if (wr_go)
            begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_ok ? AST_RESP_OK : AST_RESP_ERR;
            end
            else if (i_bready)
                o_bvalid <= 1'b0;
            if (i_arvalid & o_arready)
            begin
                o_rvalid <= 1'b1;
                o_rdata  <= {24'h000000, rd_byte};
                o_rresp  <= rd_ok ? AST_RESP_OK : AST_RESP_ERR;
            end
            else if (i_rready)
                o_rvalid <= 1'b0;
        end
    end

    // Control registers; shifter_empty bit is hardware owned
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            txsta_q <= AST_RST_TXSTA;
            rcsta_q <= AST_RST_BYTE;
            baudc_q <= AST_RST_BYTE;     // Invert defaults to 0
            brgl_q  <= AST_RST_BYTE;
            high_speed_baud_q  <= AST_RST_BYTE;
            irqen_q <= 1'b0;
        end
        else
        begin
            if (wr_txsta)
                txsta_q <= (wb & AST_TX_WMASK) | (txsta_q & ~AST_TX_WMASK);
            else
                txsta_q[AST_TX_EMPTY] <= empty_q;
            if (wr_rcsta)
                rcsta_q <= wb;
            if (wr_baudc)
                baudc_q <= wb;
            if (wr_brgl)
                brgl_q <= wb;
            if (wr_high_speed_baud)
                high_speed_baud_q <= wb;
            if (wr_flags)
                irqen_q <= wb[AST_FL_IRQEN];        // Gates nothing here
        end
    end

    // One-deep transmit buffer with ninth bit
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            txbuf_q  <= AST_RST_BYTE;
            txbuf9_q <= 1'b0;
            full_q   <= 1'b0;
        end
        else
        begin
            if (wr_txdata)
            begin
                txbuf_q  <= wb;
                txbuf9_q <= txsta_q[AST_TX_D9];
                full_q   <= 1'b1;
            end
            else if (load | ~txsta_q[AST_TX_EN])
                full_q <= 1'b0;
        end
    end

    // Buffer free flag, settling two cycles after a write
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lag_q  <= 2'h0;
            free_q <= 1'b0;
        end
        else
        begin
            if (wr_txdata)
                lag_q <= AST_FREE_LAG - 2'h1;
            else if (lag_q != 2'h0)
                lag_q <= lag_q - 2'h1;
            if (~txsta_q[AST_TX_EN])
                free_q <= 1'b0;
            else if (wr_txdata | (lag_q != 2'h0))
                free_q <= free_q;                   // Hold until settled
            else
                free_q <= ~full_q;
        end
    end

    // Shifter, baud timing and frame sequencing
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= AST_IDLE;
            shift_q <= 9'h000;
            bits_q  <= 4'h0;
            line_q  <= 1'b1;
            baud_q  <= 16'h0000;
            empty_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                AST_IDLE:
                begin
                    line_q <= 1'b1;                 // Mark while idle
                    if (load)
                    begin
                        shift_q <= {txbuf9_q, txbuf_q};
                        bits_q  <= nine ? AST_BITS_9 : AST_BITS_8;  // No parity
                        line_q  <= 1'b0;            // Start bit now
                        baud_q  <= div_val;
                        empty_q <= 1'b0;
                        state_q <= AST_SHIFT;
                    end
                end
                AST_SHIFT:
                begin
                    if (~active)
                        state_q <= AST_IDLE;
                    else if (baud_tick)
                    begin
                        baud_q  <= div_val;
                        bits_q  <= bits_q - 4'h1;
                        if (bits_q == 4'h1)
                        begin
                            line_q  <= 1'b1;        // Stop bit
                            state_q <= AST_STOP;
                        end
                        else
                        begin
                            line_q  <= shift_q[0];  // LSB first
                            shift_q <= {1'b0, shift_q[8:1]};
                        end
                    end
                    else
                        baud_q <= baud_q - 16'h0001;
                end
                AST_STOP:
                begin
                    if (~active | baud_tick)
                    begin
                        empty_q <= ~(full_q & active);  // Back to back keeps busy
                        state_q <= AST_IDLE;
                    end
                    else
                        baud_q <= baud_q - 16'h0001;
                end
                default:
                    state_q <= AST_IDLE;
            endcase
            if (state_q == AST_IDLE & ~load)
                empty_q <= 1'b1;
        end
    end

    // Pin outputs; inversion applies only in async mode
    assign o_serial_oe   = rcsta_q[AST_RC_PEN];
    assign o_serial_out  = line_q ^ (baudc_q[AST_BC_INV]
                                     & ~txsta_q[AST_TX_SYNC]);
    assign o_buffer_free = free_q;

    // Idle line stays at mark level in the idle state
    chk_idle_mark: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == AST_IDLE) |=> (state_q != AST_IDLE) || line_q)
        else $error("idle line not at mark");

    // A load drives the start bit next cycle
    chk_start_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        load |=> (line_q == 1'b0) && (state_q == AST_SHIFT))
        else $error("start bit missing after load");

    // Shifter empty clears on load
    chk_empty_clr: assert property (@(posedge i_core_clk) disable iff (i_rst)
        load |=> !empty_q)
        else $error("shifter empty not cleared");

    // Stop bit is mark
    chk_stop_mark: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == AST_STOP) |-> line_q)
        else $error("stop bit not mark");

    // Inactive transmitter never loads
    chk_gate_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !active |-> !load)
        else $error("load while inactive");

    // Flag holds for the settle cycle after a write
    sequence s_buf_write;
        wr_txdata;
    endsequence
    chk_free_lag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_buf_write ##1 !wr_txdata |=> $stable(free_q))
        else $error("free flag moved before settling");

    // Enabled with empty buffer and settled gives flag set
    chk_free_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (txsta_q[AST_TX_EN] && !full_q && lag_q == 2'h0 && !wr_txdata) |=> free_q)
        else $error("free flag not set");

    // Output polarity follows invert in async mode
    chk_invert: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !txsta_q[AST_TX_SYNC] |-> (o_serial_out == (line_q ^ baudc_q[AST_BC_INV])))
        else $error("polarity wrong");

    // First data bit after start is buffer LSB
    chk_lsb_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == AST_SHIFT && baud_tick && active && bits_q > 4'h1)
        |=> line_q == $past(shift_q[0]))
        else $error("bit order wrong");

endmodule

// File: rtl/ast_pkg.sv
/*
 * Package for the asynchronous serial transmitter: register byte offsets,
 * bit positions of control fields, reset values, state codes and timing.
 * Assumes a single 100 MHz core clock and an AXI4-Lite register bus.
 */
package ast_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [4:0] AST_OFF_TXSTA  = 5'h00;  // Transmit status/control
    localparam logic [4:0] AST_OFF_RCSTA  = 5'h04;  // Receive status/control
    localparam logic [4:0] AST_OFF_BAUDC  = 5'h08;  // Baud control
    localparam logic [4:0] AST_OFF_BRGL   = 5'h0c;  // Divisor low byte
    localparam logic [4:0] AST_OFF_HIGH_SPEED_BAUD   = 5'h10;  // Divisor high byte
    localparam logic [4:0] AST_OFF_TXDATA = 5'h14;  // Transmit buffer
    localparam logic [4:0] AST_OFF_FLAGS  = 5'h18;  // Buffer free flag / irq enable

    // transmit_status_control fields
    localparam int AST_TX_SYNC   = 4;   // Synchronous select
    localparam int AST_TX_EN     = 5;   // Transmit enable
    localparam int AST_TX_NINE   = 6;   // Nine bit transmit
    localparam int AST_TX_HIGHSP = 2;   // High speed baud
    localparam int AST_TX_EMPTY  = 1;   // Shifter empty (read only)
    localparam int AST_TX_D9     = 0;   // Ninth transmit bit
    localparam logic [7:0] AST_TX_WMASK = 8'hfd;  // Bits software may write

    // receive_status_control fields
    localparam int AST_RC_PEN    = 7;   // Port enable
    // baud_control fields
    localparam int AST_BC_INV    = 4;   // Transmit invert
    localparam int AST_BC_WIDE   = 3;   // Wide baud divider
    // flags register fields
    localparam int AST_FL_FREE   = 0;   // Buffer free flag (read only)
    localparam int AST_FL_IRQEN  = 1;   // Transmit irq enable

    // Reset values
    localparam logic [7:0] AST_RST_TXSTA = 8'h02;   // Shifter reads empty
    localparam logic [7:0] AST_RST_BYTE  = 8'h00;

    // Frame geometry
    localparam logic [3:0] AST_BITS_8    = 4'h9;    // Start + 8 data
    localparam logic [3:0] AST_BITS_9    = 4'ha;    // Start + 9 data

    // Flag settling: valid in third cycle after a buffer write
    localparam logic [1:0] AST_FREE_LAG  = 2'h2;

    // AXI responses
    localparam logic [1:0] AST_RESP_OK   = 2'h0;
    localparam logic [1:0] AST_RESP_ERR  = 2'h2;

    // Shifter states, one-hot
    typedef enum logic [2:0] {
        AST_IDLE  = 3'b001,
        AST_SHIFT = 3'b010,
        AST_STOP  = 3'b100
    } ast_state_t;

endpackage

// File: tb/ast_line_receiver.sv
/*
 * Model of the remote receiver that listens on the serial line.
 * Assumes the bench gives it bit period, polarity and character length.
 */
`timescale 1ns/1ps

module ast_line_receiver (
    input  wire logic        i_clk,    // Core clock
    input  wire logic        i_line,   // Serial line
    input  wire logic        i_inv,    // Line is low-true
    input  wire logic        i_nine,   // Nine data bits
    input  wire logic        i_on,     // Listening
    input  wire logic [15:0] i_per,    // Bit period in cycles
    output logic      [8:0]  o_data,   // Last character
    output logic      [31:0] o_count,  // Characters seen
    output logic      [31:0] o_ferr,   // Bad stop bits seen
    output logic      [31:0] o_run     // Last space run length
);
    logic [8:0]  sh;                   // Bits being assembled
    logic [31:0] run = 32'h0;          // Current space run
    wire  logic  lvl = i_line ^ i_inv; // True level

    initial
    begin
        o_count = 32'h0;
        o_ferr  = 32'h0;
        o_run   = 32'h0;
    end

    // Length of each space run, used to time the start bit
    always @(posedge i_clk)
        if (lvl == 1'b0)
            run <= run + 1;
        else
        begin
            if (run != 0)
                o_run <= run;
            run <= 32'h0;
        end

    // Start bit, then mid-bit samples LSB first, then the stop bit
    always
    begin
        @(posedge i_clk);
        if (i_on && lvl == 1'b0)
        begin
            repeat (i_per / 2) @(posedge i_clk);
            sh = 9'h0;
            for (int i = 0; i < (i_nine ? 9 : 8); i++)
            begin
                repeat (i_per) @(posedge i_clk);
                sh[i] = lvl;
            end
            repeat (i_per) @(posedge i_clk);
            if (lvl != 1'b1)
                o_ferr <= o_ferr + 1;
            o_data  <= sh;
            o_count <= o_count + 1;
        end
    end
endmodule

// File: tb/test_async_serial_transmitter.sv
/*
 * Self-checking bench: AXI4-Lite register tasks and a line receiver model.
 * Assumes the transmitter package and a 100 MHz core clock.
 */
`timescale 1ns/1ps

module test_async_serial_transmitter;
    import ast_pkg::*;

    logic        i_core_clk = 1'b0;    // Core clock
    logic        i_rst;                // Reset, active high
    logic [4:0]  i_awaddr, i_araddr;   // Bus addresses
    logic        i_awvalid, i_wvalid, i_arvalid, i_bready, i_rready;
    logic [31:0] i_wdata;              // Write data
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;     // Responses
    logic [31:0] o_rdata;              // Read data
    logic        o_serial_out, o_serial_oe, o_buffer_free;
    logic        inv, nine, on;        // Receiver settings
    logic [15:0] per;                  // Bit period
    logic [8:0]  rx_data;              // Received character
    logic [31:0] rx_count, rx_ferr, rx_run;
    logic [31:0] rdv;                  // Last read value
    logic [1:0]  resp;                 // Last response
    int          err_count, n_checks, n_rx, cyc;
    logic [15:0] bad [3] = '{16'h8030, 16'h8000, 16'h0020}; // Refused set-ups

    always #5 i_core_clk = ~i_core_clk;

    ast_transmitter i_ast_transmitter (
        .i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(4'hf), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_serial_out(o_serial_out), .o_serial_oe(o_serial_oe),
        .o_buffer_free(o_buffer_free)
    );

    ast_line_receiver i_ast_line_receiver (
        .i_clk(i_core_clk), .i_line(o_serial_out), .i_inv(inv), .i_nine(nine),
        .i_on(on), .i_per(per), .o_data(rx_data), .o_count(rx_count),
        .o_ferr(rx_ferr), .o_run(rx_run)
    );

    // Compare one result and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Print counts and verdict, then end the run
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Register write: address and data offered together, held until taken
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_awaddr  <= a;
        i_wdata   <= {24'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        resp = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_core_clk);
    endtask

    // Register read, data taken at the edge where rvalid is seen
    task automatic rd(input logic [4:0] a);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        rdv  = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_core_clk);
    endtask

    // Wait until the receiver holds the expected number of characters
    task automatic wait_rx;
        while (rx_count < n_rx) @(posedge i_core_clk);
    endtask

    // Send one character and compare what the receiver saw
    task automatic send(input logic [7:0] d, input logic [8:0] e);
        wr(AST_OFF_TXDATA, d);
        n_rx++;
        wait_rx();
        chk(rx_data, e);
    endtask

    // Hang guard
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            stop_test();
        end
    end

    initial
    begin
        {i_rst, inv, nine, on} = 4'h8;
        {i_awvalid, i_wvalid, i_arvalid, i_bready, i_rready} = 5'h0;
        {i_awaddr, i_araddr, i_wdata} = '0;
        per = 16'h4;
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        chk(o_serial_out, 1'b1);
        chk({o_serial_oe, o_buffer_free}, 2'h0);
        rd(AST_OFF_TXSTA);
        chk(rdv, AST_RST_TXSTA);
        rd(5'h1c);
        chk(resp, AST_RESP_ERR);
        chk(rdv, 32'h0);
        wr(5'h1c, 8'h00);
        chk(resp, AST_RESP_ERR);
        $display("test reset done");
        wr(AST_OFF_BRGL, 8'h03);
        chk(resp, AST_RESP_OK);
        wr(AST_OFF_RCSTA, 8'h80);
        chk(o_serial_oe, 1'b1);
        wr(AST_OFF_TXSTA, 8'h20);
        chk(o_buffer_free, 1'b1);
        wr(AST_OFF_FLAGS, 8'h02);
        rd(AST_OFF_FLAGS);
        chk(rdv, 32'h3);
        wr(AST_OFF_FLAGS, 8'h00);
        rd(AST_OFF_FLAGS);
        chk(rdv, 32'h1);
        $display("test setup done");
        on <= 1'b1;
        wr(AST_OFF_FLAGS, 8'h02);
        wr(AST_OFF_TXDATA, 8'hff);
        wr(AST_OFF_TXDATA, 8'h3c);
        wr(AST_OFF_FLAGS, 8'h00);
        chk(o_buffer_free, 1'b0);
        rd(AST_OFF_TXSTA);
        chk(rdv[AST_TX_EMPTY], 1'b0);
        n_rx = 1;
        wait_rx();
        chk(rx_data, 9'h0ff);
        chk(rx_run, 32'h4);
        n_rx = 2;
        wait_rx();
        chk(rx_data, 9'h03c);
        do rd(AST_OFF_TXSTA); while (rdv[AST_TX_EMPTY] !== 1'b1);
        chk(o_buffer_free, 1'b1);
        $display("test queue done");
        nine <= 1'b1;
        wr(AST_OFF_TXSTA, 8'h61);
        send(8'h55, 9'h155);
        wr(AST_OFF_TXSTA, 8'h60);
        send(8'haa, 9'h0aa);
        nine <= 1'b0;
        wr(AST_OFF_TXSTA, 8'h20);
        $display("test nine done");
        on <= 1'b0;
        wr(AST_OFF_BAUDC, 8'h10);
        inv <= 1'b1;
        on  <= 1'b1;
        chk(o_serial_out, 1'b0);
        send(8'h96, 9'h096);
        on <= 1'b0;
        wr(AST_OFF_TXSTA, 8'h30);
        chk(o_serial_out, 1'b1);
        wr(AST_OFF_TXSTA, 8'h20);
        wr(AST_OFF_BAUDC, 8'h00);
        inv <= 1'b0;
        $display("test invert done");
        wr(AST_OFF_HIGH_SPEED_BAUD, 8'h01);
        wr(AST_OFF_BAUDC, 8'h08);
        per <= 16'd260;
        on  <= 1'b1;
        send(8'hff, 9'h0ff);
        chk(rx_run, 32'd260);
        $display("test wide done");
        foreach (bad[k])
        begin
            wr(AST_OFF_RCSTA, bad[k][15:8]);
            wr(AST_OFF_TXSTA, bad[k][7:0]);
            wr(AST_OFF_TXDATA, 8'h5a);
            repeat (12 * 260) @(posedge i_core_clk);
            chk(rx_count, n_rx);
        end
        chk(o_serial_oe, 1'b0);
        chk(rx_ferr, 32'h0);
        $display("test refuse done");
        stop_test();
    end
endmodule
